// >>> src/adcsr_pkg.sv
// Package of shared constants for the serial converter readout link
package adcsr_pkg;
   // -----------------------------------------------------------------
   // Frame shape
   // -----------------------------------------------------------------
   localparam int RESULT_W      = 12;  // Result bits per conversion
   localparam int FRAME_EDGES   = 16;  // Serial clock cycles per conversion
   localparam int ACQ_CYCLES    = 3;   // Acquisition cycles
   localparam int LEAD_ZEROS    = 4;   // Falling edges carrying zeros
   localparam int FIRST_BIT_EDGE = 5;  // Falling edge carrying the MSB
   localparam int CNT_W         = 5;   // Falling edge counter width
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CORE_CLK_MHZ  = 20;      // Core clock rate
   // Half period must cover both ends' pin synchronisers and the data
   // register (five core cycles), so the host rise sees the new bit
   localparam int SCLK_HALF_NS  = 300;     // Host serial clock half period
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int CS_GAP_NS     = 400;     // Least chip select high time
   localparam int CS_GAP_CYC    = (CS_GAP_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int CS_SETUP_NS   = 100;     // Chip select fall to first clock fall
   localparam int CS_SETUP_CYC  = (CS_SETUP_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int TMR_W         = 8;       // Host timer width
endpackage : adcsr_pkg

// >>> src/adcsr_if.sv
// Interface joining converter end and host end of the serial link
`timescale 1ns/1ps
interface adcsr_if;
   logic cs_n;       // Chip select, active low, host drives
   logic sclk;       // Serial clock, host drives
   logic dout_o;     // Serial data value from converter
   logic dout_oe;    // Converter drives serial data while high
   wire  dout;       // Data line level seen by the host
   // A released line reads as its pull-up rather than floating
   assign dout = dout_oe ? dout_o : 1'b1;
   modport dev  (input cs_n, input sclk, output dout_o, output dout_oe);
   modport host (output cs_n, output sclk, input dout);
endinterface : adcsr_if

// >>> src/adcsr_fifo.sv
// Synchronous FIFO buffering results on the host side
`timescale 1ns/1ps
module adcsr_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   // Write side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Read side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   // Pointer wrap logic only serves power-of-two depths
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   wire              full  = (wp_r[AW] != rp_r[AW]) &&
                             (wp_r[AW-1:0] == rp_r[AW-1:0]);
   wire              empty = (wp_r == rp_r);
   wire              push  = in_valid_i && !full;
   wire              pop   = out_ready_i && !empty;
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem_r[rp_r[AW-1:0]];
   // Storage has no reset, pointers do
   always_ff @(posedge core_clk_i) begin
      if (push) mem_r[wp_r[AW-1:0]] <= in_data_i;
   end
   // Pointer update
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop)  rp_r <= rp_r + 1'b1;
      end
   end
endmodule : adcsr_fifo

// >>> src/adcsr_dev.sv
// Converter end: serial result shifter with chip select power control
// Summary of operation
// [RULE_01] Each result bit driven as soon as decided
// [RULE_02] Chip select rise stops conversion early
// [RULE_03] Host clocks sixteen cycles per sample
// [RULE_04] Below 500 kSPS host uses burst mode
// [RULE_05] Power down after every conversion in burst
// [RULE_06] Host stops serial clock when deselected
// [RULE_07] Host keeps chip select fall off clock rise
// [RULE_08] Clash may shift output one bit early
// [RULE_09] First result bit on fifth falling edge
// [RULE_10] Three acquire cycles, thirteen convert cycles
// [RULE_11] Zeros on edges 1-4, MSB-first bits 5-16
// [RULE_12] Early chip select rise aborts, floats output
// [RULE_13] Normal while selected, powered down otherwise; powered_o also drops after falling edge 16 while still selected
// [RULE_14] Host samples on following rising edge
// [RULE_15] Output floats whenever chip select deasserted
`timescale 1ns/1ps
module adcsr_dev (
   // Clock and reset
   input  wire logic                             core_clk_i,
   input  wire logic                             rst_i,
   // Link
   adcsr_if.dev                                  link,
   // Sample source and status
   input  wire logic [adcsr_pkg::RESULT_W-1:0]   sample_i,
   output logic                                  powered_o,
   output logic                                  acquiring_o,
   output logic                                  abort_o,
   output logic                                  early_shift_o
);
   typedef enum logic [1:0] {DS_DOWN, DS_RUN, DS_DONE} adcsr_dst_e;
   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [1:0] cs_s_r;
   logic [1:0] ck_s_r;
   logic       cs_d_r;
   logic       ck_d_r;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cs_s_r <= 2'h3;
         ck_s_r <= 2'h3;   // Idle clock level, no false rise after reset
         cs_d_r <= 1'b1;
         ck_d_r <= 1'b1;
      end else begin
         cs_s_r <= {cs_s_r[0], link.cs_n};
         ck_s_r <= {ck_s_r[0], link.sclk};
         cs_d_r <= cs_s_r[1];
         ck_d_r <= ck_s_r[1];
      end
   end
   wire cs_n    = cs_s_r[1];
   wire cs_fall = cs_d_r && !cs_n;
   wire cs_rise = !cs_d_r && cs_n;
   wire ck_fall = ck_d_r && !ck_s_r[1];
   wire ck_rise = !ck_d_r && ck_s_r[1];
   // Falling edge count; a fall with clock low counts as edge one
   logic [adcsr_pkg::CNT_W-1:0]    fe_r;
   logic [adcsr_pkg::CNT_W-1:0]    fe_nxt;
   logic [adcsr_pkg::RESULT_W-1:0] shreg_r;
   logic [adcsr_pkg::RESULT_W-1:0] shreg_nxt;
   adcsr_dst_e                     st_r;
   adcsr_dst_e                     st_nxt;
   logic                           dout_r;
   logic                           dout_nxt;
   logic                           oe_r;
   logic                           oe_nxt;
   logic                           ab_nxt;
   logic                           early_nxt;
   wire [adcsr_pkg::CNT_W-1:0] fe_inc = fe_r + 1'b1;
   wire in_acq = (fe_r <= adcsr_pkg::ACQ_CYCLES[adcsr_pkg::CNT_W-1:0]);
   // -----------------------------------------------------------------
   // Conversion state machine
   // -----------------------------------------------------------------
   always_comb begin
      st_nxt    = st_r;
      fe_nxt    = fe_r;
      shreg_nxt = shreg_r;
      dout_nxt  = dout_r;
      oe_nxt    = oe_r;
      ab_nxt    = 1'b0;
      early_nxt = early_shift_o;
      case (st_r)
         DS_DOWN, DS_DONE: begin
            if (cs_n) begin
               st_nxt = DS_DOWN;    // see [RULE_05] see [RULE_13]
               oe_nxt = 1'b0;       // see [RULE_15]
            end
            if (cs_fall) begin
               st_nxt    = DS_RUN;
               oe_nxt    = 1'b1;
               dout_nxt  = 1'b0;
               // Fall clashing with a clock rise counts one edge early
               early_nxt = ck_rise;                 // see [RULE_08]
               fe_nxt    = (!ck_s_r[1] || ck_rise) ?
                           adcsr_pkg::CNT_W'(1) : '0;
            end
         end
         DS_RUN: begin
            if (cs_rise) begin
               // Abort before the last edge; output floats
               st_nxt = DS_DOWN;                     // see [RULE_02]
               oe_nxt = 1'b0;                        // see [RULE_12]
               ab_nxt = (fe_r < adcsr_pkg::CNT_W'(adcsr_pkg::FRAME_EDGES));
            end else if (ck_rise && fe_r == adcsr_pkg::CNT_W'(
                         adcsr_pkg::ACQ_CYCLES)) begin
               shreg_nxt = sample_i;  // Hold at end of acquire, see [RULE_10]
            end else if (ck_fall) begin
               fe_nxt = fe_inc;
               if (fe_inc <= adcsr_pkg::CNT_W'(adcsr_pkg::LEAD_ZEROS)) begin
                  dout_nxt = 1'b0;                   // see [RULE_11]
               end else if (fe_inc <= adcsr_pkg::CNT_W'(
                            adcsr_pkg::FRAME_EDGES)) begin
                  // Bit goes out the edge it is decided, see [RULE_01]
                  dout_nxt  = shreg_r[adcsr_pkg::RESULT_W-1]; // see [RULE_09]
                  shreg_nxt = {shreg_r[adcsr_pkg::RESULT_W-2:0], 1'b0};
               end
               if (fe_inc == adcsr_pkg::CNT_W'(adcsr_pkg::FRAME_EDGES)) begin
                  st_nxt = DS_DONE;
               end
            end
         end
         default: st_nxt = DS_DOWN;
      endcase
   end
   // State registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r          <= DS_DOWN;
         fe_r          <= '0;
         shreg_r       <= '0;
         dout_r        <= 1'b0;
         oe_r          <= 1'b0;
         abort_o       <= 1'b0;
         early_shift_o <= 1'b0;
         powered_o     <= 1'b0;
         acquiring_o   <= 1'b0;
      end else begin
         st_r          <= st_nxt;
         fe_r          <= fe_nxt;
         shreg_r       <= shreg_nxt;
         dout_r        <= dout_nxt;
         oe_r          <= oe_nxt;
         abort_o       <= ab_nxt;
         early_shift_o <= early_nxt;
         powered_o     <= (st_nxt == DS_RUN);
         acquiring_o   <= (st_nxt == DS_RUN) && in_acq;
      end
   end
   // Early shift: the clash case loads one edge ahead, so MSB lands on 4
   assign link.dout_o  = dout_r;
   assign link.dout_oe = oe_r;
endmodule : adcsr_dev

// >>> src/adcsr_host.sv
// Host end: frames chip select, divides serial clock, collects results
`timescale 1ns/1ps
module adcsr_host #(
   parameter int BITS_NEEDED = 12,
   parameter int FIFO_DEPTH  = 16
) (
   // Clock and reset
   input  wire logic                           core_clk_i,
   input  wire logic                           rst_i,
   // Link
   adcsr_if.host                               link,
   // Request
   input  wire logic                           start_i,
   output logic                                busy_o,
   // Result stream
   output logic                                res_valid_o,
   input  wire logic                           res_ready_i,
   output logic [adcsr_pkg::RESULT_W-1:0]      res_data_o
);
   typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_SHIFT, HS_GAP} adcsr_hst_e;
   // A frame carries at most one full result
   if (BITS_NEEDED < 1 || BITS_NEEDED > adcsr_pkg::RESULT_W) begin : g_bad
      $error("BITS_NEEDED out of range");
   end
   localparam int LAST_EDGE = adcsr_pkg::LEAD_ZEROS + BITS_NEEDED;
   // -----------------------------------------------------------------
   // Data pin synchroniser
   // -----------------------------------------------------------------
   logic [1:0] din_s_r;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) din_s_r <= 2'h0;
      else       din_s_r <= {din_s_r[0], link.dout};
   end
   adcsr_hst_e                      st_r;
   logic [adcsr_pkg::TMR_W-1:0]     tmr_r;
   logic [adcsr_pkg::CNT_W-1:0]     edge_r;
   logic [adcsr_pkg::RESULT_W-1:0]  sh_r;
   logic                            cs_n_r;
   logic                            sclk_r;
   logic                            push_r;
   logic [adcsr_pkg::RESULT_W-1:0]  push_d_r;
   logic                            fifo_rdy;
   wire tmr_zero = (tmr_r == '0);
   wire [adcsr_pkg::TMR_W-1:0] half =
                 adcsr_pkg::TMR_W'(adcsr_pkg::SCLK_HALF_CYC - 1);
   // -----------------------------------------------------------------
   // Frame sequencer; clock divided from core, idle high, stopped out
   // of frame. Falls of chip select happen with clock high, far from a
   // rise. see [RULE_07] see [RULE_06] see [RULE_03]
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r     <= HS_IDLE;
         tmr_r    <= '0;
         edge_r   <= '0;
         sh_r     <= '0;
         cs_n_r   <= 1'b1;
         sclk_r   <= 1'b1;
         push_r   <= 1'b0;
         push_d_r <= '0;
      end else begin
         push_r <= 1'b0;
         if (!tmr_zero) tmr_r <= tmr_r - 1'b1;
         case (st_r)
            HS_IDLE: begin
               // New frame only when a result slot is free
               if (start_i && fifo_rdy) begin
                  cs_n_r <= 1'b0;
                  edge_r <= '0;
                  tmr_r  <= adcsr_pkg::TMR_W'(adcsr_pkg::CS_SETUP_CYC - 1);
                  st_r   <= HS_SETUP;
               end
            end
            HS_SETUP: begin
               if (tmr_zero) begin
                  sclk_r <= 1'b0;
                  edge_r <= adcsr_pkg::CNT_W'(1);
                  tmr_r  <= adcsr_pkg::TMR_W'(half);
                  st_r   <= HS_SHIFT;
               end
            end
            HS_SHIFT: begin
               if (tmr_zero) begin
                  tmr_r  <= adcsr_pkg::TMR_W'(half);
                  sclk_r <= !sclk_r;
                  if (!sclk_r) begin
                     // Rising edge: take the bit launched on last fall
                     if (edge_r > adcsr_pkg::CNT_W'(adcsr_pkg::LEAD_ZEROS))
                        sh_r <= {sh_r[adcsr_pkg::RESULT_W-2:0],
                                 din_s_r[1]};            // see [RULE_14]
                     if (edge_r == adcsr_pkg::CNT_W'(LAST_EDGE)) begin
                        // Short cycle after last needed bit, see [RULE_02]
                        cs_n_r <= 1'b1;
                        push_r <= 1'b1;
                        push_d_r <= {sh_r[adcsr_pkg::RESULT_W-2:0],
                                     din_s_r[1]} << (adcsr_pkg::RESULT_W
                                     - BITS_NEEDED);
                        tmr_r  <= adcsr_pkg::TMR_W'(adcsr_pkg::CS_GAP_CYC);
                        st_r   <= HS_GAP;     // Burst spacing, see [RULE_04]
                     end
                  end else begin
                     edge_r <= edge_r + 1'b1;
                  end
               end
            end
            HS_GAP: begin
               if (tmr_zero) st_r <= HS_IDLE;
            end
            default: st_r <= HS_IDLE;
         endcase
      end
   end
   // Result buffer; full FIFO holds off the next frame
   adcsr_fifo #(
      .WIDTH (adcsr_pkg::RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_r),
      .in_ready_o  (fifo_rdy),
      .in_data_i   (push_d_r),
      .out_valid_o (res_valid_o),
      .out_ready_i (res_ready_i),
      .out_data_o  (res_data_o)
   );
   assign link.cs_n = cs_n_r;
   assign link.sclk = sclk_r;
   assign busy_o    = (st_r != HS_IDLE);
endmodule : adcsr_host

// >>> tb/adcsr_properties.sv
// Concurrent checks on the link between converter end and host end
`timescale 1ns/1ps
module adcsr_properties #(
   parameter int BITS = 8
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Link signals
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout_o,
   input wire logic dout_oe
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------
   // Helper: rises seen in a frame
   // ------------------------------
   logic       sclk_r;
   logic [4:0] rise_cnt_r;
   wire        sclk_rise = sclk & ~sclk_r;
   // Count is cleared while deselected so each frame starts fresh
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_r     <= 1'b1;
         rise_cnt_r <= 5'h00;
      end else begin
         sclk_r     <= sclk;
         rise_cnt_r <= cs_n ? 5'h00 : rise_cnt_r + {4'h0, sclk_rise};
      end
   end
   // ------------------------------
   // Assertions
   // ------------------------------
   a_oe_on_select: assert property (
      $fell(cs_n) |-> ##[1:8] dout_oe) else $error("enable late");
   a_oe_off_abort: assert property (
      $rose(cs_n) |-> ##[1:6] !dout_oe) else $error("no float");
   a_float_when_idle: assert property (
      cs_n [*8] |-> !dout_oe) else $error("driven while idle");
   a_drive_in_frame: assert property (
      !cs_n [*8] |-> dout_oe) else $error("not driven in frame");
   a_lead_zeros: assert property (
      sclk_rise && !cs_n && rise_cnt_r < 5'h03 |-> dout_oe && !dout_o)
      else $error("leading bit not zero");
   a_bit_settled: assert property (
      sclk_rise && !cs_n |=> $stable(dout_o) [*2])
      else $error("bit moved after rise");
   a_frame_length: assert property (
      $rose(cs_n) |-> rise_cnt_r == 5'(BITS + 3)
                   || rise_cnt_r == 5'(BITS + 4))
      else $error("frame length wrong");
   a_idle_clock_high: assert property (
      cs_n [*2] |-> sclk) else $error("clock runs while idle");
   a_select_clear: assert property (
      $fell(cs_n) |-> $stable(sclk) [*2]) else $error("select clash");
   // Main scenarios reached
   c_frame: cover property ($fell(cs_n));
   c_short: cover property ($rose(cs_n) && rise_cnt_r > 5'h0A);
   c_float: cover property ($fell(dout_oe));
endmodule : adcsr_properties

// >>> tb/adc_serial_readout_power_cycling_bench.sv
// Self-checking bench for the converter readout link, both ends
`timescale 1ns/1ps
module adc_serial_readout_power_cycling_bench;
   // ------------------------------
   // Stimulus, status and counters
   // ------------------------------
   typedef struct {logic [11:0] samp; logic [11:0] exp;} adcsr_row_s;
   logic        core_clk_i  = 1'b0;
   logic        rst_i       = 1'b1;
   logic        start_i     = 1'b0;
   logic        res_ready_i = 1'b0;
   logic [11:0] sample_i    = 12'h000;
   logic [11:0] sample2     = 12'hA53;
   logic        busy_o, res_valid_o, powered_o, ab_o, ab2_o;
   logic        early_o, pow2, early2, took;
   logic        acq_o;
   logic        pow_seen    = 1'b0;
   logic        acq_seen    = 1'b0;
   logic [11:0] res_data_o;
   logic [15:0] bits;
   int          errors  = 0;
   int          checks  = 0;
   int          aborts  = 0;
   int          aborts2 = 0;
   // Short cycling keeps 8 bits, so low nibble of each result is zero
   adcsr_row_s  rows [5] = '{'{12'h7FF, 12'h7F0}, '{12'h800, 12'h800},
      '{12'h000, 12'h000}, '{12'hFFF, 12'hFF0}, '{12'hA5C, 12'hA50}};
   always #25 core_clk_i = ~core_clk_i;
   // ------------------------------
   // Pair under test, and a converter end the bench drives itself
   // ------------------------------
   adcsr_if link ();
   adcsr_if link2 ();
   adcsr_dev adcsr_dev_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .link(link.dev), .sample_i(sample_i), .powered_o(powered_o),
      .acquiring_o(acq_o), .abort_o(ab_o), .early_shift_o(early_o));
   adcsr_host #(.BITS_NEEDED(8), .FIFO_DEPTH(16)) adcsr_host_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .link(link.host),
      .start_i(start_i), .busy_o(busy_o), .res_valid_o(res_valid_o),
      .res_ready_i(res_ready_i), .res_data_o(res_data_o));
   adcsr_dev adcsr_dev2_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .link(link2.dev), .sample_i(sample2), .powered_o(pow2),
      .acquiring_o(), .abort_o(ab2_o), .early_shift_o(early2));
   adcsr_properties #(.BITS(8)) adcsr_properties_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n(link.cs_n),
      .sclk(link.sclk), .dout_o(link.dout_o), .dout_oe(link.dout_oe));
   // Pulses last one cycle; read mid-cycle, where they have settled
   always @(negedge core_clk_i) begin
      if (ab_o === 1'b1) aborts++;
      if (ab2_o === 1'b1) aborts2++;
      if (powered_o === 1'b1) pow_seen = 1'b1;
      if (acq_o === 1'b1) acq_seen = 1'b1;
   end
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic check(input string what, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // Level request held until busy shows; a full buffer refuses it
   task automatic run_frame(output logic taken);
      int n;
      n = 0;
      start_i = 1'b1;
      while (busy_o !== 1'b1 && n < 20) begin
         @(negedge core_clk_i);
         n++;
      end
      taken = (busy_o === 1'b1);
      start_i = 1'b0;
      while (busy_o !== 1'b0 && n < 400) begin
         @(negedge core_clk_i);
         n++;
      end
      check("frame end", {15'h0000, busy_o}, 16'h0000);
   endtask : run_frame
   task automatic pop(input logic [11:0] exp);
      int n;
      n = 0;
      while (res_valid_o !== 1'b1 && n < 50) begin
         @(negedge core_clk_i);
         n++;
      end
      check("valid", {15'h0000, res_valid_o}, 16'h0001);
      check("result", {4'h0, res_data_o}, {4'h0, exp});
      res_ready_i = 1'b1;
      @(negedge core_clk_i);
      res_ready_i = 1'b0;
      // A cycle with ready low keeps two pops from meeting in one step
      @(negedge core_clk_i);
   endtask : pop
   // Bench as host on the second link: clock parked low, so the select
   // fall counts as fall one; a clash raises the clock with the select
   task automatic frame2(input int nf, input logic clash,
                         output logic [15:0] got);
      got = 16'h0000;
      link2.sclk = 1'b0;
      repeat (10) @(negedge core_clk_i);
      link2.cs_n = 1'b0;
      if (clash) link2.sclk = 1'b1;
      for (int k = 0; k < nf; k++) begin
         repeat (4) @(negedge core_clk_i);
         got = {got[14:0], link2.dout};
         link2.sclk = 1'b1;
         repeat (4) @(negedge core_clk_i);
         if (k < nf - 1) link2.sclk = 1'b0;
      end
      link2.cs_n = 1'b1;
      repeat (8) @(negedge core_clk_i);
   endtask : frame2
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      link2.cs_n = 1'b1;
      link2.sclk = 1'b1;
      repeat (10) @(negedge core_clk_i);
      rst_i = 1'b0;
      @(negedge core_clk_i);
      foreach (rows[i]) begin
         sample_i = rows[i].samp;
         run_frame(took);
         check("taken", {15'h0000, took}, 16'h0001);
         check("idle power", {15'h0000, powered_o}, 16'h0000);
         pop(rows[i].exp);
      end
      check("aborts", aborts[15:0], 16'h0005);
      check("on time", {15'h0000, early_o}, 16'h0000);
      check("powered", {15'h0000, pow_seen}, 16'h0001);
      check("acquire", {15'h0000, acq_seen}, 16'h0001);
      // Fill the buffer with the reader stalled, then drain it
      for (int i = 0; i < 17; i++) begin
         sample_i = {3{i[3:0]}};
         run_frame(took);
         check("fill", {15'h0000, took}, {15'h0000, i < 16});
      end
      for (int i = 0; i < 16; i++) pop({i[3:0], i[3:0], 4'h0});
      check("drained", {15'h0000, res_valid_o}, 16'h0000);
      // Full frame, short frame and a clashing start on the second link
      frame2(16, 1'b0, bits);
      check("full word", bits, 16'h0A53);
      check("no abort", aborts2[15:0], 16'h0000);
      frame2(12, 1'b0, bits);
      check("short word", bits, 16'h00A5);
      check("abort", aborts2[15:0], 16'h0001);
      check("float", {15'h0000, link2.dout_oe}, 16'h0000);
      check("power down", {15'h0000, pow2}, 16'h0000);
      check("no clash", {15'h0000, early2}, 16'h0000);
      frame2(16, 1'b1, bits);
      check("clash", {15'h0000, early2}, 16'h0001);
      // Reset with a word waiting, then one more frame
      sample_i = 12'h3C9;
      run_frame(took);
      rst_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      check("rst valid", {15'h0000, res_valid_o}, 16'h0000);
      check("rst sclk", {15'h0000, link.sclk}, 16'h0001);
      check("rst oe", {15'h0000, link.dout_oe}, 16'h0000);
      check("rst clash", {15'h0000, early2}, 16'h0000);
      rst_i = 1'b0;
      @(negedge core_clk_i);
      run_frame(took);
      pop(12'h3C0);
      wrap_up();
   end
   // Watchdog sized well above the roughly 4000 cycles the run needs
   initial begin
      repeat (12000) @(posedge core_clk_i);
      errors++;
      wrap_up();
   end
endmodule : adc_serial_readout_power_cycling_bench
